// file: rtl/ascfg_consts.vh
// Purpose: constants for the setup and filter configuration register bank
// Assumes: APB byte addresses are four times the register index
// Notes:   definitions only
`ifndef ASCFG_CONSTS_VH
`define ASCFG_CONSTS_VH

// register indexes and byte addresses
`define ASCFG_IDX_SETUP2     8'h22
`define ASCFG_IDX_SETUP3     8'h23
`define ASCFG_IDX_FILTER0    8'h28
`define ASCFG_IDX_STATUS     8'h30
`define ASCFG_IDX_LATCH      8'h31
`define ASCFG_IDX_RATE       8'h32
`define ASCFG_ADDR_SETUP2    10'h088
`define ASCFG_ADDR_SETUP3    10'h08c
`define ASCFG_ADDR_FILTER0   10'h0a0
`define ASCFG_ADDR_STATUS    10'h0c0
`define ASCFG_ADDR_LATCH     10'h0c4
`define ASCFG_ADDR_RATE      10'h0c8

// reset values
`define ASCFG_SETUP_RST      16'h1020
`define ASCFG_FILTER_RST     16'h0000

// writable masks, everything else reserved
`define ASCFG_SETUP_MASK     16'h1030
`define ASCFG_FILTER_MASK    16'h8f7f
`define ASCFG_DIRECT_MASK    16'hffff

// setup fields
`define ASCFG_CODING_BIT     12
`define ASCFG_REF_HI         5
`define ASCFG_REF_LO         4
`define ASCFG_REF_EXT        2'h0
`define ASCFG_REF_INT        2'h2
`define ASCFG_REF_SUPPLY     2'h3

// filter fields
`define ASCFG_DIRECT_BIT     15
`define ASCFG_DEC_HI         14
`define ASCFG_POST_EN_BIT    11
`define ASCFG_POST_HI        10
`define ASCFG_POST_LO        8
`define ASCFG_ORDER_HI       6
`define ASCFG_ORDER_LO       5
`define ASCFG_RATE_HI        4
`define ASCFG_RATE_LO        0
`define ASCFG_ORDER_SINC5    2'h0
`define ASCFG_ORDER_SINC3    2'h3
`define ASCFG_POST_27        3'h2
`define ASCFG_POST_25        3'h3
`define ASCFG_POST_20        3'h5
`define ASCFG_POST_16        3'h6
`define ASCFG_RATE_LAST      5'h14

// direct sinc3 decimation factor
`define ASCFG_DEC_FACTOR     6'h20

`endif

// file: rtl/ascfg_regs.v
// Purpose: setup 2/3 and filter 0 configuration registers behind APB
// Assumes: 32-bit APB, zero wait states, SYS_CLK at 25 MHz
// Notes:   decoded filter settings go to the conversion engine
`timescale 1ns/1ps
`default_nettype none
`include "ascfg_consts.vh"

module ascfg_regs (
   input  wire        SYS_CLK,
   input  wire        ARST_N,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   input  wire        CONV_START,
   output reg         CODING_S2,
   output reg  [1:0]  REFERENCE_S2,
   output reg         CODING_S3,
   output reg  [1:0]  REFERENCE_S3,
   output reg         DIRECT_DECIMATION,
   output reg  [14:0] DECIMATION_RATE,
   output reg  [1:0]  FILTER_ORDER,
   output reg         POST_FILTER_ACTIVE,
   output reg  [2:0]  POST_FILTER_CHOICE,
   output reg  [4:0]  OUTPUT_RATE_CODE,
   output reg         CONFIG_VALID
);

////////////////////////////////////////////////////////////////////////////////
// reset release and conversion start synchroniser

reg        rst_meta;
reg        rst_sync;
reg        start_meta;
reg        start_sync;
reg        start_prev;

always @(posedge SYS_CLK or negedge ARST_N) begin
   if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
   end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
   end
end

// start comes from the converter pin side, so it is synchronised
always @(posedge SYS_CLK or negedge rst_sync) begin
   if (!rst_sync) begin
      start_meta <= 1'b0;
      start_sync <= 1'b0;
      start_prev <= 1'b0;
   end else begin
      start_meta <= CONV_START;
      start_sync <= start_meta;
      start_prev <= start_sync;
   end
end

wire conv_edge = start_sync & ~start_prev;

////////////////////////////////////////////////////////////////////////////////
// software visible registers

reg  [15:0] setup_cfg_2;
reg  [15:0] setup_cfg_3;
reg  [15:0] filter_cfg_0;
reg         pending;

// direct mapping opens bits 14:12 and 7 too, since all 15 bits are the divider
function [15:0] ascfg_filter_mask;
   input [15:0] value;
   begin
      if (value[`ASCFG_DIRECT_BIT])
         ascfg_filter_mask = value & `ASCFG_DIRECT_MASK;
      else
         ascfg_filter_mask = value & `ASCFG_FILTER_MASK;
   end
endfunction

// byte address compare; upper address bits must be clear for any hit
function ascfg_hit;
   input [11:0] addr;
   input [9:0]  target;
   begin
      ascfg_hit = (addr[11:10] == 2'h0) & (addr[9:0] == target);
   end
endfunction

// setup registers keep only the coding and reference bits
function [15:0] ascfg_setup_mask;
   input [15:0] value;
   begin
      ascfg_setup_mask = value & `ASCFG_SETUP_MASK;
   end
endfunction

wire        apb_access = PSEL & PENABLE;
wire        apb_setup  = PSEL & ~PENABLE;
wire        apb_write  = apb_access & PWRITE;
wire        hit_s2     = ascfg_hit(PADDR, `ASCFG_ADDR_SETUP2);
wire        hit_s3     = ascfg_hit(PADDR, `ASCFG_ADDR_SETUP3);
wire        hit_f0     = ascfg_hit(PADDR, `ASCFG_ADDR_FILTER0);
wire        hit_st     = ascfg_hit(PADDR, `ASCFG_ADDR_STATUS);
wire        hit_lt     = ascfg_hit(PADDR, `ASCFG_ADDR_LATCH);
wire        hit_rt     = ascfg_hit(PADDR, `ASCFG_ADDR_RATE);
wire        hit_any    = hit_s2 | hit_s3 | hit_f0 | hit_st | hit_lt | hit_rt;
wire        cfg_write  = apb_write & (hit_s2 | hit_s3 | hit_f0);

////////////////////////////////////////////////////////////////////////////////
// register writes and the pending flag

always @(posedge SYS_CLK or negedge rst_sync) begin
   if (!rst_sync) begin
      setup_cfg_2 <= `ASCFG_SETUP_RST;
      setup_cfg_3 <= `ASCFG_SETUP_RST;
   end else if (apb_write) begin
      if (hit_s2)
         setup_cfg_2 <= ascfg_setup_mask(PWDATA[15:0]);
      if (hit_s3)
         setup_cfg_3 <= ascfg_setup_mask(PWDATA[15:0]);
   end
end

// filter write is masked according to its own mode bit
always @(posedge SYS_CLK or negedge rst_sync) begin
   if (!rst_sync)
      filter_cfg_0 <= `ASCFG_FILTER_RST;
   else if (apb_write & hit_f0)
      filter_cfg_0 <= ascfg_filter_mask(PWDATA[15:0]);
end

// pending: set by a write, cleared when a conversion latches; set wins
always @(posedge SYS_CLK or negedge rst_sync) begin
   if (!rst_sync)
      pending <= 1'b0;
   else if (cfg_write)
      pending <= 1'b1;
   else if (conv_edge)
      pending <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// decode of the filter register, applied only at a conversion start

wire        f_direct = filter_cfg_0[`ASCFG_DIRECT_BIT];
wire [1:0]  f_order  = filter_cfg_0[`ASCFG_ORDER_HI:`ASCFG_ORDER_LO];
wire [2:0]  f_post   = filter_cfg_0[`ASCFG_POST_HI:`ASCFG_POST_LO];
wire [4:0]  f_rate   = filter_cfg_0[`ASCFG_RATE_HI:`ASCFG_RATE_LO];

// only the four listed post filters are real choices
function ascfg_post_legal;
   input [2:0] sel;
   begin
      case (sel)
         `ASCFG_POST_27: ascfg_post_legal = 1'b1;
         `ASCFG_POST_25: ascfg_post_legal = 1'b1;
         `ASCFG_POST_20: ascfg_post_legal = 1'b1;
         `ASCFG_POST_16: ascfg_post_legal = 1'b1;
         default:        ascfg_post_legal = 1'b0;
      endcase
   end
endfunction

reg         next_direct;
reg  [14:0] next_decim;
reg  [1:0]  next_order;
reg         next_post_act;
reg  [2:0]  next_post;
reg  [4:0]  next_rate;

always @* begin
   next_direct   = f_direct;
   next_decim    = 15'h0;
   next_order    = f_order;
   next_post_act = 1'b0;
   next_post     = f_post;
   next_rate     = f_rate;
   if (f_direct) begin
      // other options drop out; engine divides by 32 times this value
      next_decim    = filter_cfg_0[`ASCFG_DEC_HI:0];
      next_order    = `ASCFG_ORDER_SINC3;
      next_post     = 3'h0;
      next_rate     = 5'h00;
   end else begin
      next_post_act = filter_cfg_0[`ASCFG_POST_EN_BIT] &
                      (f_order == `ASCFG_ORDER_SINC5) &
                      ascfg_post_legal(f_post);
      // codes past the slowest rate clamp to it
      if (f_rate > `ASCFG_RATE_LAST)
         next_rate = `ASCFG_RATE_LAST;
   end
end

////////////////////////////////////////////////////////////////////////////////
// settings to the engine, latched at each conversion start

// holding outputs until a start keeps an in-flight result self-consistent
always @(posedge SYS_CLK or negedge rst_sync) begin
   if (!rst_sync) begin
      CODING_S2    <= 1'b1;
      REFERENCE_S2 <= `ASCFG_REF_INT;
      CODING_S3    <= 1'b1;
      REFERENCE_S3 <= `ASCFG_REF_INT;
   end else if (conv_edge) begin
      CODING_S2    <= setup_cfg_2[`ASCFG_CODING_BIT];
      REFERENCE_S2 <= setup_cfg_2[`ASCFG_REF_HI:`ASCFG_REF_LO];
      CODING_S3    <= setup_cfg_3[`ASCFG_CODING_BIT];
      REFERENCE_S3 <= setup_cfg_3[`ASCFG_REF_HI:`ASCFG_REF_LO];
   end
end

// filter settings move on the same start, never mid-conversion
always @(posedge SYS_CLK or negedge rst_sync) begin
   if (!rst_sync) begin
      DIRECT_DECIMATION  <= 1'b0;
      DECIMATION_RATE    <= 15'h0;
      FILTER_ORDER       <= `ASCFG_ORDER_SINC5;
      POST_FILTER_ACTIVE <= 1'b0;
      POST_FILTER_CHOICE <= 3'h0;
      OUTPUT_RATE_CODE   <= 5'h00;
   end else if (conv_edge) begin
      DIRECT_DECIMATION  <= next_direct;
      DECIMATION_RATE    <= next_decim;
      FILTER_ORDER       <= next_order;
      POST_FILTER_ACTIVE <= next_post_act;
      POST_FILTER_CHOICE <= next_post;
      OUTPUT_RATE_CODE   <= next_rate;
   end
end

always @(posedge SYS_CLK or negedge rst_sync) begin
   if (!rst_sync)
      CONFIG_VALID <= 1'b0;
   else if (conv_edge)
      CONFIG_VALID <= 1'b1;
end

////////////////////////////////////////////////////////////////////////////////
// APB read path; answer in the access cycle, registered

reg  [31:0] next_rdata;

always @* begin
   next_rdata = 32'h00000000;
   case (1'b1)
      hit_s2:  next_rdata = {16'h0000, setup_cfg_2};
      hit_s3:  next_rdata = {16'h0000, setup_cfg_3};
      hit_f0:  next_rdata = {16'h0000, filter_cfg_0};
      hit_st:  next_rdata = {30'h0, CONFIG_VALID, pending};
      hit_lt:  next_rdata = {16'h0000, DIRECT_DECIMATION, DECIMATION_RATE};
      hit_rt:  next_rdata = {20'h00000, POST_FILTER_ACTIVE, POST_FILTER_CHOICE,
                             1'b0, FILTER_ORDER, OUTPUT_RATE_CODE};
      default: next_rdata = 32'h00000000;
   endcase
end

// PREADY is a one-cycle pulse: registered from setup, so ready in the access cycle
always @(posedge SYS_CLK or negedge rst_sync) begin
   if (!rst_sync)
      PREADY <= 1'b0;
   else
      PREADY <= apb_setup;
end

// read data only in the ready cycle of a read, zero otherwise
always @(posedge SYS_CLK or negedge rst_sync) begin
   if (!rst_sync)
      PRDATA <= 32'h00000000;
   else if (apb_setup & ~PWRITE)
      PRDATA <= next_rdata;
   else
      PRDATA <= 32'h00000000;
end

// unmapped addresses answer with an error; writes there are dropped
always @(posedge SYS_CLK or negedge rst_sync) begin
   if (!rst_sync)
      PSLVERR <= 1'b0;
   else
      PSLVERR <= apb_setup & ~hit_any;
end

endmodule // ascfg_regs

`default_nettype wire

// file: dv/ascfg_regs_assertions.sv
// Purpose: port checks for the setup and filter config bank
// Assumes: one clock domain, zero wait APB
// Notes:   bound to ascfg_regs at the foot
`timescale 1ns/1ps
`default_nettype none
module ascfg_checker (
   input wire logic        SYS_CLK,
   input wire logic        ARST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        CONV_START,
   input wire logic        CODING_S2,
   input wire logic [1:0]  REFERENCE_S2,
   input wire logic        DIRECT_DECIMATION,
   input wire logic [14:0] DECIMATION_RATE,
   input wire logic [1:0]  FILTER_ORDER,
   input wire logic        POST_FILTER_ACTIVE,
   input wire logic [2:0]  POST_FILTER_CHOICE,
   input wire logic [4:0]  OUTPUT_RATE_CODE,
   input wire logic        CONFIG_VALID
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   a_setup_gets_ready: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready after setup");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   a_error_with_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
      else $error("error without ready or with data");
   a_reserved_read_zero: assert property (PREADY && (PADDR == 12'h088 || PADDR == 12'h08c)
      |-> (PRDATA & ~32'h1030) == 32'h0) else $error("reserved setup bits not zero");
   a_direct_forces: assert property (DIRECT_DECIMATION |-> FILTER_ORDER == 2'h3
      && !POST_FILTER_ACTIVE && POST_FILTER_CHOICE == 3'h0 && OUTPUT_RATE_CODE == 5'h0)
      else $error("direct mode left other options");
   a_rate_only_direct: assert property (!DIRECT_DECIMATION |-> DECIMATION_RATE == 15'h0)
      else $error("decimation rate outside direct mode");
   a_post_needs_sinc5: assert property (POST_FILTER_ACTIVE |-> FILTER_ORDER == 2'h0
      && POST_FILTER_CHOICE inside {3'h2, 3'h3, 3'h5, 3'h6})
      else $error("post filter active wrongly");
   a_rate_clamped: assert property (OUTPUT_RATE_CODE <= 5'h14)
      else $error("rate code past last entry");
   a_rdata_idle_zero: assert property (!PREADY |-> PRDATA == 32'h0)
      else $error("read data outside a ready cycle");
   // generous window: start goes through a two flop synchroniser
   a_hold_between: assert property (!CONV_START && !$past(CONV_START) &&
      !$past(CONV_START, 2) && !$past(CONV_START, 3) && !$past(CONV_START, 4)
      && !$past(CONV_START, 5) |-> $stable({CODING_S2, REFERENCE_S2, DIRECT_DECIMATION,
      FILTER_ORDER, OUTPUT_RATE_CODE})) else $error("outputs moved without a start");
   a_valid_after_start: assert property ($rose(CONV_START) |-> ##[2:6] CONFIG_VALID)
      else $error("config valid missing after start");
endmodule // ascfg_checker
bind ascfg_regs ascfg_checker u_ascfg_checker (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
   .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .CONV_START(CONV_START), .CODING_S2(CODING_S2),
   .REFERENCE_S2(REFERENCE_S2), .DIRECT_DECIMATION(DIRECT_DECIMATION),
   .DECIMATION_RATE(DECIMATION_RATE), .FILTER_ORDER(FILTER_ORDER),
   .POST_FILTER_ACTIVE(POST_FILTER_ACTIVE), .POST_FILTER_CHOICE(POST_FILTER_CHOICE),
   .OUTPUT_RATE_CODE(OUTPUT_RATE_CODE), .CONFIG_VALID(CONFIG_VALID));
`default_nettype wire

// file: dv/adc_setup_filter_config_regs_tb_top.sv
// Purpose: random and corner tests of the config bank over APB
// Assumes: zero wait APB, start latched within a few cycles
// Notes:   expectations from masks and field rules
`timescale 1ns/1ps
`default_nettype none
`include "ascfg_consts.vh"
module adc_setup_filter_config_regs_tb_top;
   logic        clk, rst_n, psel, pen, pwr, cs, pready, perr, c2, c3, dd, pact, valid, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [14:0] drate;
   logic [1:0]  r2, r3, ford;
   logic [2:0]  pch;
   logic [4:0]  rcode;
   logic [15:0] s2, s3, f;
   logic [2:0]  pc [4] = '{3'h2, 3'h3, 3'h5, 3'h6};
   logic [1:0]  rf [3] = '{2'h0, 2'h2, 2'h3};
   int          n_mismatch = 0;
   int          checks_done = 0;
   ascfg_regs u_ascfg_regs (.SYS_CLK(clk), .ARST_N(rst_n), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(perr), .CONV_START(cs), .CODING_S2(c2), .REFERENCE_S2(r2), .CODING_S3(c3),
      .REFERENCE_S3(r3), .DIRECT_DECIMATION(dd), .DECIMATION_RATE(drate),
      .FILTER_ORDER(ford), .POST_FILTER_ACTIVE(pact), .POST_FILTER_CHOICE(pch),
      .OUTPUT_RATE_CODE(rcode), .CONFIG_VALID(valid));
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // idle cycle first, so strobes never get two assignments in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         n_mismatch++;
         results();
      end else begin
         rd = prdata;
         er = perr;
         psel <= 0;
         pen <= 0;
      end
   endtask
   task automatic conv;
      @(posedge clk);
      cs <= 1;
      @(posedge clk);
      cs <= 0;
      repeat (7) @(posedge clk);
   endtask
   function automatic logic [31:0] fexp(input logic [15:0] v);
      logic [2:0] ch;
      logic [4:0] rc;
      logic       act;
      ch = v[10:8];
      rc = (v[4:0] > 5'h14) ? 5'h14 : v[4:0];
      act = v[11] && v[6:5] == 2'h0 && (ch == 3'h2 || ch == 3'h3 || ch == 3'h5 || ch == 3'h6);
      if (v[15]) return {5'h0, 1'b1, v[14:0], 2'h3, 1'b0, 3'h0, 5'h0};
      return {5'h0, 1'b0, 15'h0, v[6:5], act, ch, rc};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, psel, pen, pwr, cs} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      void'($urandom(32'hafc0efdc));
      repeat (20) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      chk("reset outputs", 32'h36, {valid, c2, r2, c3, r3});
      chk("reset filter outs", 32'h0, {dd, drate, ford, pact, pch, rcode});
      apb(0, `ASCFG_ADDR_SETUP2, 0);
      chk("setup2 reset", 32'h1020, rd);
      apb(0, `ASCFG_ADDR_FILTER0, 0);
      chk("filter0 reset", 32'h0, rd);
      apb(1, 12'h0fc, 32'hffff);
      apb(0, 12'h0fc, 0);
      chk("unmapped", 32'h1, {rd[30:0], er});
      for (int i = 0; i < 24; i++) begin
         s2 = $urandom;
         s3 = $urandom;
         f = $urandom;
         s2[5:4] = rf[i % 3];
         s3[5:4] = rf[(i + 1) % 3];
         f[6] = f[5];
         if (i % 3 == 0) f = {4'h0, 1'b1, pc[(i / 3) % 4], 3'h0, f[4:0]};
         if (i % 3 == 1) f[15] = 1'b1;
         if (i == 2) f = 16'h0074;
         if (i == 5) f = 16'h0015;
         apb(1, `ASCFG_ADDR_SETUP2, s2);
         apb(1, `ASCFG_ADDR_SETUP3, s3);
         apb(1, `ASCFG_ADDR_FILTER0, f);
         apb(0, `ASCFG_ADDR_SETUP2, 0);
         chk("setup2", s2 & `ASCFG_SETUP_MASK, rd);
         apb(0, `ASCFG_ADDR_SETUP3, 0);
         chk("setup3", s3 & `ASCFG_SETUP_MASK, rd);
         apb(0, `ASCFG_ADDR_FILTER0, 0);
         chk("filter0", f[15] ? f : f & `ASCFG_FILTER_MASK, rd);
         conv;
         chk("setup outs", {1'b1, s2[12], s2[5:4], s3[12], s3[5:4]},
             {valid, c2, r2, c3, r3});
         chk("filter outs", fexp(f), {dd, drate, ford, pact, pch, rcode});
         apb(0, `ASCFG_ADDR_STATUS, 0);
         chk("status", 32'h2, rd);
         apb(1, `ASCFG_ADDR_SETUP2, ~s2);
         chk("held coding", s2[12], c2);
         apb(0, `ASCFG_ADDR_STATUS, 0);
         chk("status pending", 32'h3, rd);
      end
      rst_n <= 0;
      repeat (3) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      chk("rereset outputs", 32'h36, {valid, c2, r2, c3, r3});
      apb(0, `ASCFG_ADDR_SETUP3, 0);
      chk("setup3 rereset", 32'h1020, rd);
      results();
   end
endmodule // adc_setup_filter_config_regs_tb_top
`default_nettype wire
